// File: design/power_clock_manager.v
// Clock manager: master, processor, usb, peripheral and output clocks
//
// Notes on behaviour
// - Master clock: source select, power-two prescale 1..64
// - Master divider lets processor outrun master clock
// - Master config write clears ready until established
// - System disable stops processor clock; status shows
// - Processor clock on after reset, interrupt re-enables
// - Gating waits for instruction end; bus unaffected
// - USB clock always from second PLL
// - USB host clock enable, disable, status bits
// - USB host gets usb and master clocks
// - Each peripheral clock gated separately, with status
// - Peripheral disable immediate; all off after reset
// - Peripheral bit position equals peripheral identifier
// - Two programmable clock outputs, separately configured
// - Output source choice, power-two prescale 1..64
// - Enable/disable bits start, stop outputs; status
// - Output ready flag once matching its configuration
// - No glitch prevention on output reconfiguration
// - Oscillator enable bit starts it, with count
// - Oscillator stable flag pollable and interruptible
// - Second PLL change clears lock until count expires
`timescale 1ns/1ns
`include "power_clock_manager_defines.vh"

module power_clock_manager #(
  parameter NUM_PERIPH = 32
) (
  // Clock and reset
  input  wire                  sys_clk_in,
  input  wire                  rstn_in,
  // Register port
  input  wire [7:0]            reg_addr_in,
  input  wire [31:0]           reg_wdata_in,
  input  wire                  reg_wr_in,
  input  wire                  reg_rd_in,
  output reg  [31:0]           reg_rdata_out,
  // Generator clock edges, one-cycle pulses
  input  wire                  slow_tick_in,
  input  wire                  main_tick_in,
  input  wire                  pll1_tick_in,
  input  wire                  pll2_tick_in,
  // Processor core handshake
  input  wire                  instr_done_in,
  input  wire                  irq_fast_in,
  input  wire                  irq_normal_in,
  // Gated clock edges
  output wire                  master_clock_out,
  output wire                  processor_clock_out,
  output wire                  usb_host_clock_out,
  output wire [NUM_PERIPH-1:0] periph_clock_out,
  // Programmable clock pins and interrupt
  output reg  [1:0]            prog_clock_out,
  output wire                  irq_out
);

  // ========================================================
  // Helpers

  // Source edge selected by a clock source field
  function src_pick;
    input [1:0] clock_source_select;
    input       slow;
    input       mainc;
    input       pll1;
    input       pll2;
    begin
      case (clock_source_select)
        `CSS_SLOW: src_pick = slow;
        `CSS_MAIN: src_pick = mainc;
        `CSS_PLL1: src_pick = pll1;
        default:   src_pick = pll2;
      endcase
    end
  endfunction

  // Terminal count of a power-of-two prescaler
  function [5:0] prescaler_select_limit;
    input [2:0] prescaler_select;
    reg   [2:0] p;
    begin
      p = (prescaler_select > `PRESCALER_SELECT_MAX) ? `PRESCALER_SELECT_MAX : prescaler_select;
      prescaler_select_limit = 6'h3F >> (3'h6 - p);
    end
  endfunction

  // ========================================================
  // Register state
  reg                  proc_en_r;
  reg                  proc_off_pend_r;
  reg                  usb_en_r;
  reg  [1:0]           prog_en_r;
  reg  [NUM_PERIPH-1:0] periph_en_r;
  reg  [9:0]           mclk_cfg_r;
  reg  [4:0]           prog_cfg_r [0:1];
  reg                  osc_en_r;
  reg  [7:0]           osc_cnt_r;
  reg  [2:0]           osc_div_r;
  reg                  osc_stable_r;
  reg  [29:0]          pll_cfg_r;
  reg  [5:0]           pll_cnt_r;
  reg                  pll_lock_r;
  reg                  mclk_rdy_r;
  reg  [5:0]           mclk_pcnt_r;
  reg  [1:0]           mclk_dcnt_r;
  reg  [5:0]           prog_cnt_r [0:1];
  reg  [1:0]           prog_rdy_r;
  reg  [1:0]           usb_cnt_r;
  reg  [9:0]           int_mask_r;
  integer              i, j;

  // Write decodes
  wire wr_sys_en  = reg_wr_in & (reg_addr_in == `SYS_CLK_EN_ADDR);
  wire wr_sys_dis = reg_wr_in & (reg_addr_in == `SYS_CLK_DIS_ADDR);
  wire wr_per_en  = reg_wr_in & (reg_addr_in == `PER_CLK_EN_ADDR);
  wire wr_per_dis = reg_wr_in & (reg_addr_in == `PER_CLK_DIS_ADDR);
  wire wr_osc     = reg_wr_in & (reg_addr_in == `MAIN_OSC_ADDR);
  wire wr_pll     = reg_wr_in & (reg_addr_in == `PLL2_CFG_ADDR);
  wire wr_mclk    = reg_wr_in & (reg_addr_in == `MCLK_CFG_ADDR);
  wire wr_int_en  = reg_wr_in & (reg_addr_in == `INT_EN_ADDR);
  wire wr_int_dis = reg_wr_in & (reg_addr_in == `INT_DIS_ADDR);
  wire [1:0] wr_prog;
  assign wr_prog[0] = reg_wr_in & (reg_addr_in == `PROG0_CFG_ADDR);
  assign wr_prog[1] = reg_wr_in & (reg_addr_in == `PROG1_CFG_ADDR);

  // ========================================================
  // Master clock path

  // Unlocked second PLL falls back to the main clock
  wire [1:0] mclk_css = mclk_cfg_r[`CSS_MSB:`CSS_LSB];
  wire [1:0] mclk_src = (mclk_css == `CSS_PLL2 && !pll_lock_r) ?
                        `CSS_MAIN : mclk_css;
  wire mclk_src_tick  = src_pick(mclk_src, slow_tick_in, main_tick_in,
                                 pll1_tick_in, pll2_tick_in);
  wire proc_tick = mclk_src_tick &
      (mclk_pcnt_r == prescaler_select_limit(mclk_cfg_r[`PRESCALER_SELECT_MSB:`PRESCALER_SELECT_LSB]));
  wire [1:0] master_divider_select_lim = (mclk_cfg_r[`MASTER_DIVIDER_SELECT_MSB:`MASTER_DIVIDER_SELECT_LSB] == 2'h0) ?
                        2'h0 :
                        (mclk_cfg_r[`MASTER_DIVIDER_SELECT_MSB:`MASTER_DIVIDER_SELECT_LSB] == 2'h1) ?
                        2'h1 : 2'h3;
  wire mclk_tick = proc_tick & (mclk_dcnt_r == master_divider_select_lim);

  // Prescaler and divider counters, restarted by a config write
  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mclk_pcnt_r <= 6'h00;
      mclk_dcnt_r <= 2'h0;
    end else if (wr_mclk) begin
      mclk_pcnt_r <= 6'h00;
      mclk_dcnt_r <= 2'h0;
    end else begin
      if (proc_tick)
        mclk_pcnt_r <= 6'h00;
      else if (mclk_src_tick)
        mclk_pcnt_r <= mclk_pcnt_r + 6'h01;
      if (mclk_tick)
        mclk_dcnt_r <= 2'h0;
      else if (proc_tick)
        mclk_dcnt_r <= mclk_dcnt_r + 2'h1;
    end
  end

  // Config and ready flag; ready returns on first new master edge
  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mclk_cfg_r <= 10'h000;
      mclk_rdy_r <= 1'b1;
    end else if (wr_mclk) begin
      mclk_cfg_r <= {reg_wdata_in[`MASTER_DIVIDER_SELECT_MSB:`MASTER_DIVIDER_SELECT_LSB], 3'h0,
                     reg_wdata_in[`PRESCALER_SELECT_MSB:`CSS_LSB]};
      mclk_rdy_r <= 1'b0;
    end else if (mclk_css == `CSS_PLL2 && !pll_lock_r) begin
      mclk_rdy_r <= 1'b0;
    end else if (mclk_tick) begin
      mclk_rdy_r <= 1'b1;
    end
  end

  assign master_clock_out = mclk_tick;

  // ========================================================
  // Processor clock: disable waits for instruction end

  wire proc_wake = irq_fast_in | irq_normal_in;
  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      proc_en_r       <= 1'b1;
      proc_off_pend_r <= 1'b0;
    end else if (proc_wake) begin
      proc_en_r       <= 1'b1;
      proc_off_pend_r <= 1'b0;
    end else if (wr_sys_en && reg_wdata_in[`SYS_PROC_BIT]) begin
      proc_en_r       <= 1'b1;
      proc_off_pend_r <= 1'b0;
    end else if (wr_sys_dis && reg_wdata_in[`SYS_PROC_BIT]) begin
      proc_off_pend_r <= 1'b1;
      if (instr_done_in)
        proc_en_r <= 1'b0;
    end else if (proc_off_pend_r && instr_done_in) begin
      proc_en_r       <= 1'b0;
      proc_off_pend_r <= 1'b0;
    end
  end

  // Only the core clock stops; master clock keeps the bus going
  assign processor_clock_out = proc_tick & proc_en_r;

  // ========================================================
  // USB host clock from the second PLL, divided by 1, 2 or 4

  wire [1:0] usb_sel = pll_cfg_r[`PLL_USB_MSB:`PLL_USB_LSB];
  wire [1:0] usb_lim = (usb_sel == 2'h0) ? 2'h0 :
                       (usb_sel == 2'h1) ? 2'h1 : 2'h3;
  wire usb_tick = pll2_tick_in & (usb_cnt_r == usb_lim);

  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      usb_cnt_r <= 2'h0;
      usb_en_r  <= 1'b0;
    end else begin
      if (usb_tick)
        usb_cnt_r <= 2'h0;
      else if (pll2_tick_in)
        usb_cnt_r <= usb_cnt_r + 2'h1;
      if (wr_sys_en && reg_wdata_in[`SYS_USB_BIT])
        usb_en_r <= 1'b1;
      else if (wr_sys_dis && reg_wdata_in[`SYS_USB_BIT])
        usb_en_r <= 1'b0;
    end
  end

  assign usb_host_clock_out = usb_tick & usb_en_r & pll_lock_r;

  // ========================================================
  // Peripheral clocks, bit index is the peripheral identifier

  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in)
      periph_en_r <= {NUM_PERIPH{1'b0}};
    else if (wr_per_en)
      periph_en_r <= periph_en_r |
                     reg_wdata_in[NUM_PERIPH-1:0];
    else if (wr_per_dis)
      periph_en_r <= periph_en_r &
                     ~reg_wdata_in[NUM_PERIPH-1:0];
  end

  // Disable acts on the next master edge with no wait
  assign periph_clock_out = periph_en_r &
                            {NUM_PERIPH{mclk_tick}};

  // ========================================================
  // Programmable clock outputs (no glitch guard on reconfig)

  reg [1:0] prog_tick;
  always @* begin
    for (j = 0; j < 2; j = j + 1)
      prog_tick[j] = src_pick(prog_cfg_r[j][`CSS_MSB:`CSS_LSB],
                              slow_tick_in, main_tick_in,
                              pll1_tick_in, pll2_tick_in) &
                     (prog_cnt_r[j] ==
                      prescaler_select_limit(prog_cfg_r[j][`PRESCALER_SELECT_MSB:`PRESCALER_SELECT_LSB]));
  end

  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      prog_en_r      <= 2'h0;
      prog_rdy_r     <= 2'h0;
      prog_clock_out <= 2'h0;
      for (i = 0; i < 2; i = i + 1) begin
        prog_cfg_r[i] <= 5'h00;
        prog_cnt_r[i] <= 6'h00;
      end
    end else begin
      for (i = 0; i < 2; i = i + 1) begin
        if (wr_prog[i]) begin
          prog_cfg_r[i] <= reg_wdata_in[`PRESCALER_SELECT_MSB:`CSS_LSB];
          prog_cnt_r[i] <= 6'h00;
          prog_rdy_r[i] <= 1'b0;
        end else if (prog_tick[i]) begin
          prog_cnt_r[i] <= 6'h00;
        end else if (src_pick(prog_cfg_r[i][`CSS_MSB:`CSS_LSB],
                              slow_tick_in, main_tick_in,
                              pll1_tick_in, pll2_tick_in)) begin
          prog_cnt_r[i] <= prog_cnt_r[i] + 6'h01;
        end
        if (wr_sys_en && reg_wdata_in[`SYS_PROG_LSB + i])
          prog_en_r[i] <= 1'b1;
        else if (wr_sys_dis && reg_wdata_in[`SYS_PROG_LSB + i])
          prog_en_r[i] <= 1'b0;
        if (!prog_en_r[i]) begin
          prog_clock_out[i] <= 1'b0;
          prog_rdy_r[i]     <= 1'b0;
        end else if (prog_tick[i] && !wr_prog[i]) begin
          prog_clock_out[i] <= ~prog_clock_out[i];
          prog_rdy_r[i]     <= 1'b1;
        end
      end
    end
  end

  // ========================================================
  // Main oscillator start-up count on slow clock divided by 8

  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      osc_en_r     <= 1'b0;
      osc_cnt_r    <= 8'h00;
      osc_div_r    <= 3'h0;
      osc_stable_r <= 1'b0;
    end else if (wr_osc) begin
      osc_en_r     <= reg_wdata_in[`OSC_EN_BIT];
      osc_cnt_r    <= reg_wdata_in[`OSC_CNT_MSB:`OSC_CNT_LSB];
      osc_div_r    <= 3'h0;
      osc_stable_r <= 1'b0;
    end else if (osc_en_r && !osc_stable_r) begin
      if (osc_cnt_r == 8'h00)
        osc_stable_r <= 1'b1;
      else if (slow_tick_in) begin
        osc_div_r <= osc_div_r + 3'h1;
        if (osc_div_r == `OSC_SLOW_DIV)
          osc_cnt_r <= osc_cnt_r - 8'h01;
      end
    end
  end

  // ========================================================
  // Second PLL lock count on slow clock

  wire pll_change = wr_pll &&
    (reg_wdata_in[`PLL_MUL_MSB:`PLL_MUL_LSB] !=
       pll_cfg_r[`PLL_MUL_MSB:`PLL_MUL_LSB] ||
     reg_wdata_in[`PLL_DIV_MSB:`PLL_DIV_LSB] !=
       pll_cfg_r[`PLL_DIV_MSB:`PLL_DIV_LSB]);
  wire pll_on = pll_cfg_r[`PLL_MUL_MSB:`PLL_MUL_LSB] != 11'h000 &&
                pll_cfg_r[`PLL_DIV_MSB:`PLL_DIV_LSB] != 8'h00;

  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pll_cfg_r  <= 30'h0000_0000;
      pll_cnt_r  <= 6'h00;
      pll_lock_r <= 1'b0;
    end else begin
      if (wr_pll)
        pll_cfg_r <= reg_wdata_in[29:0];
      if (pll_change) begin
        pll_cnt_r  <= reg_wdata_in[`PLL_CNT_MSB:`PLL_CNT_LSB];
        pll_lock_r <= 1'b0;
      end else if (pll_on && !pll_lock_r) begin
        if (pll_cnt_r == 6'h00)
          pll_lock_r <= 1'b1;
        else if (slow_tick_in)
          pll_cnt_r <= pll_cnt_r - 6'h01;
      end
    end
  end

  // ========================================================
  // Status, interrupt mask and shared interrupt line

  wire [9:0] status = {prog_rdy_r, 4'h0, mclk_rdy_r, pll_lock_r,
                       1'b0, osc_stable_r};
  wire [9:0] sys_stat = {prog_en_r, 1'b0, usb_en_r, 5'h00, proc_en_r};

  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in)
      int_mask_r <= 10'h000;
    else if (wr_int_en)
      int_mask_r <= int_mask_r | reg_wdata_in[9:0];
    else if (wr_int_dis)
      int_mask_r <= int_mask_r & ~reg_wdata_in[9:0];
  end

  assign irq_out = |(status & int_mask_r);

  // ========================================================
  // Read data, one cycle after the read strobe; zero elsewhere

  reg [31:0] rdata_nxt;
  always @* begin
    rdata_nxt = 32'h0000_0000;
    case (reg_addr_in)
      `SYS_CLK_STAT_ADDR: rdata_nxt = {22'h00_0000, sys_stat};
      `PER_CLK_STAT_ADDR: rdata_nxt[NUM_PERIPH-1:0] = periph_en_r;
      `MAIN_OSC_ADDR:
        rdata_nxt = {16'h0000, osc_cnt_r, 7'h00, osc_en_r};
      `PLL2_CFG_ADDR:     rdata_nxt = {2'h0, pll_cfg_r};
      `MCLK_CFG_ADDR:     rdata_nxt = {22'h00_0000, mclk_cfg_r};
      `PROG0_CFG_ADDR:    rdata_nxt = {27'h000_0000, prog_cfg_r[0]};
      `PROG1_CFG_ADDR:    rdata_nxt = {27'h000_0000, prog_cfg_r[1]};
      `STATUS_ADDR:       rdata_nxt = {22'h00_0000, status};
      `INT_MASK_ADDR:     rdata_nxt = {22'h00_0000, int_mask_r};
      default:            rdata_nxt = 32'h0000_0000;
    endcase
  end

  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in)
      reg_rdata_out <= 32'h0000_0000;
    else if (reg_rd_in)
      reg_rdata_out <= rdata_nxt;
    else
      reg_rdata_out <= 32'h0000_0000;
  end

endmodule // power_clock_manager

// File: design/power_clock_manager_defines.vh
// Register map, field layouts and constants of the clock manager
`ifndef POWER_CLOCK_MANAGER_DEFINES_VH
`define POWER_CLOCK_MANAGER_DEFINES_VH

// ==========================================================
// Register offsets (byte addresses)
`define SYS_CLK_EN_ADDR      8'h00
`define SYS_CLK_DIS_ADDR     8'h04
`define SYS_CLK_STAT_ADDR    8'h08
`define PER_CLK_EN_ADDR      8'h10
`define PER_CLK_DIS_ADDR     8'h14
`define PER_CLK_STAT_ADDR    8'h18
`define MAIN_OSC_ADDR        8'h20
`define PLL2_CFG_ADDR        8'h2C
`define MCLK_CFG_ADDR        8'h30
`define PROG0_CFG_ADDR       8'h40
`define PROG1_CFG_ADDR       8'h44
`define INT_EN_ADDR          8'h60
`define INT_DIS_ADDR         8'h64
`define STATUS_ADDR          8'h68
`define INT_MASK_ADDR        8'h6C

// ==========================================================
// System clock bits (enable, disable, status)
`define SYS_PROC_BIT         0
`define SYS_USB_BIT          6
`define SYS_PROG_LSB         8

// ==========================================================
// Clock configuration fields (master and programmable)
`define CSS_MSB              1
`define CSS_LSB              0
`define PRESCALER_SELECT_MSB             4
`define PRESCALER_SELECT_LSB             2
`define MASTER_DIVIDER_SELECT_MSB             9
`define MASTER_DIVIDER_SELECT_LSB             8
`define CSS_SLOW             2'h0
`define CSS_MAIN             2'h1
`define CSS_PLL1             2'h2
`define CSS_PLL2             2'h3
`define PRESCALER_SELECT_MAX             3'h6

// ==========================================================
// Main oscillator and second PLL fields
`define OSC_EN_BIT           0
`define OSC_CNT_MSB          15
`define OSC_CNT_LSB          8
`define OSC_SLOW_DIV         3'h7
`define PLL_DIV_MSB          7
`define PLL_DIV_LSB          0
`define PLL_CNT_MSB          13
`define PLL_CNT_LSB          8
`define PLL_MUL_MSB          26
`define PLL_MUL_LSB          16
`define PLL_USB_MSB          29
`define PLL_USB_LSB          28

// ==========================================================
// Status flag bits
`define ST_OSC_BIT           0
`define ST_LOCK_BIT          2
`define ST_MRDY_BIT          3
`define ST_PRDY_LSB          8

`endif

// File: sim/core_periph_model.sv
// Model of the core and the clock generator around the clock manager
`timescale 1ns/1ns

module core_periph_model (
  // Clock and reset
  input  wire       sys_clk_in,
  input  wire       rstn_in,
  // Bench control
  input  wire       run_in,
  input  wire       busy_in,
  input  wire       wake_in,
  input  wire       fast_in,
  // Generator ticks
  output wire       slow_tick_out,
  output wire       main_tick_out,
  output wire       pll1_tick_out,
  output wire       pll2_tick_out,
  // Core handshake
  output wire       instr_done_out,
  output wire       irq_fast_out,
  output wire       irq_normal_out
);
  reg [2:0] cnt_r;

  // Free phase counter, held while the generator is stopped
  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in)
      cnt_r <= 3'h0;
    else if (run_in)
      cnt_r <= cnt_r + 3'h1;
  end

  // Ticks: slow every 8, pll1 every 4, main and pll2 every 2 cycles
  assign slow_tick_out = run_in && cnt_r == 3'h0;
  assign main_tick_out = run_in && cnt_r[0];
  assign pll1_tick_out = run_in && cnt_r[1:0] == 2'h2;
  assign pll2_tick_out = run_in && !cnt_r[0];
  // Core finishes its instruction unless held busy
  assign instr_done_out = !busy_in;
  assign irq_fast_out = wake_in && fast_in;
  assign irq_normal_out = wake_in && !fast_in;
endmodule // core_periph_model

// File: sim/power_clock_manager_checker.sv
// Port checker of the clock manager, bound to the design
`timescale 1ns/1ns
`include "power_clock_manager_defines.vh"

module power_clock_manager_checker #(
  parameter NUM_PERIPH = 32
) (
  // Clock and reset
  input wire                  sys_clk_in,
  input wire                  rstn_in,
  // Register port
  input wire [7:0]            reg_addr_in,
  input wire [31:0]           reg_wdata_in,
  input wire                  reg_wr_in,
  input wire                  reg_rd_in,
  input wire [31:0]           reg_rdata_out,
  // Generator ticks and core
  input wire                  slow_tick_in,
  input wire                  main_tick_in,
  input wire                  pll1_tick_in,
  input wire                  pll2_tick_in,
  input wire                  instr_done_in,
  input wire                  irq_fast_in,
  input wire                  irq_normal_in,
  // Clock outputs and interrupt
  input wire                  master_clock_out,
  input wire                  processor_clock_out,
  input wire                  usb_host_clock_out,
  input wire [NUM_PERIPH-1:0] periph_clock_out,
  input wire [1:0]            prog_clock_out,
  input wire                  irq_out
);
  reg [NUM_PERIPH-1:0] pen_r;
  reg [1:0]            pgen_r;
  reg [31:0]           mask_r;

  // ==========================================================
  // Shadow enable and mask registers
  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pen_r <= {NUM_PERIPH{1'b0}};
      pgen_r <= 2'h0;
      mask_r <= 32'h0000_0000;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        `PER_CLK_EN_ADDR: pen_r <= pen_r | reg_wdata_in[NUM_PERIPH-1:0];
        `PER_CLK_DIS_ADDR: pen_r <= pen_r & ~reg_wdata_in[NUM_PERIPH-1:0];
        `SYS_CLK_EN_ADDR: pgen_r <= pgen_r | reg_wdata_in[9:8];
        `SYS_CLK_DIS_ADDR: pgen_r <= pgen_r & ~reg_wdata_in[9:8];
        `INT_EN_ADDR: mask_r <= mask_r | reg_wdata_in;
        `INT_DIS_ADDR: mask_r <= mask_r & ~reg_wdata_in;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);

  a_rdata_idle: assert property (!$past(reg_rd_in) |->
    reg_rdata_out == 32'h0000_0000) else $error("read data not idle");
  a_unmapped_read: assert property (reg_rd_in && reg_addr_in > 8'h6C
    |=> reg_rdata_out == 32'h0000_0000) else $error("unmapped read");
  a_pstat_read: assert property (reg_rd_in &&
    reg_addr_in == `PER_CLK_STAT_ADDR |=> reg_rdata_out[NUM_PERIPH-1:0]
    == $past(pen_r)) else $error("periph status mismatch");
  a_periph_gate: assert property (periph_clock_out ==
    ({NUM_PERIPH{master_clock_out}} & pen_r)) else $error("periph gate");
  a_usb_source: assert property (usb_host_clock_out |->
    pll2_tick_in) else $error("usb clock not from pll2");
  a_master_source: assert property (master_clock_out |->
    (slow_tick_in || main_tick_in || pll1_tick_in || pll2_tick_in))
    else $error("master pulse without source");
  a_prog_off: assert property (!(reg_wr_in &&
    reg_addr_in == `SYS_CLK_EN_ADDR) |=> (prog_clock_out &
    ~$past(pgen_r)) == 2'h0) else $error("disabled output moves");
  a_irq_masked: assert property (mask_r == 32'h0000_0000 |->
    !irq_out) else $error("interrupt while masked");
endmodule // power_clock_manager_checker

bind power_clock_manager power_clock_manager_checker #(
  .NUM_PERIPH(NUM_PERIPH)
) u_chk (
  .sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .slow_tick_in(slow_tick_in),
  .main_tick_in(main_tick_in), .pll1_tick_in(pll1_tick_in),
  .pll2_tick_in(pll2_tick_in), .instr_done_in(instr_done_in),
  .irq_fast_in(irq_fast_in), .irq_normal_in(irq_normal_in),
  .master_clock_out(master_clock_out),
  .processor_clock_out(processor_clock_out),
  .usb_host_clock_out(usb_host_clock_out),
  .periph_clock_out(periph_clock_out),
  .prog_clock_out(prog_clock_out), .irq_out(irq_out)
);

// File: sim/power_clock_manager_tb_top.sv
// Self-checking testbench of the clock manager
`timescale 1ns/1ns
`include "power_clock_manager_defines.vh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
`define WAITFOR(x) begin k = 0; while ((x) !== 1'b1 && k < 200) begin \
  @(posedge clk); #1; k++; end if (k == 200) begin n_mismatch++; \
  finish_test; end end

module power_clock_manager_tb_top;
  reg         clk = 1'b0;
  reg         rstn = 1'b0;
  reg  [7:0]  addr = 8'h00;
  reg  [31:0] wdata = 32'h0000_0000;
  reg         wr = 1'b0;
  reg         rd = 1'b0;
  reg         run = 1'b0;
  reg         busy = 1'b0;
  reg         wake = 1'b0;
  reg         fast = 1'b0;
  wire [31:0] rdata;
  wire [31:0] pclk;
  wire [1:0]  prog;
  wire        slow, mainc, pll1, pll2, idone, irqf, irqn;
  wire        mclk, prclk, uclk, irq;
  integer     n_mismatch = 0;
  integer     num_checks = 0;
  integer     i, k, mc, pc;
  reg  [31:0] d;
  reg  [1:0]  p;

  // ==========================================================
  // Clock, partner and design
  always #20 clk = ~clk;

  core_periph_model u_far (
    .sys_clk_in(clk), .rstn_in(rstn), .run_in(run), .busy_in(busy),
    .wake_in(wake), .fast_in(fast), .slow_tick_out(slow),
    .main_tick_out(mainc), .pll1_tick_out(pll1), .pll2_tick_out(pll2),
    .instr_done_out(idone), .irq_fast_out(irqf), .irq_normal_out(irqn));

  power_clock_manager #(.NUM_PERIPH(32)) u_dut (
    .sys_clk_in(clk), .rstn_in(rstn), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .slow_tick_in(slow), .main_tick_in(mainc),
    .pll1_tick_in(pll1), .pll2_tick_in(pll2), .instr_done_in(idone),
    .irq_fast_in(irqf), .irq_normal_in(irqn), .master_clock_out(mclk),
    .processor_clock_out(prclk), .usb_host_clock_out(uclk),
    .periph_clock_out(pclk), .prog_clock_out(prog), .irq_out(irq));

  // ==========================================================
  // Bus cycles and waits
  task finish_test;
    begin
      if (n_mismatch == 0 && num_checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask

  task wr_reg(input [7:0] a, input [31:0] v);
    begin
      @(posedge clk);
      addr <= a; wdata <= v; wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask

  task rd_reg(input [7:0] a);
    begin
      @(posedge clk);
      addr <= a; rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
    end
  endtask

  // Poll one status bit until set, bounded
  task poll(input integer b);
    begin
      rd_reg(`STATUS_ADDR);
      for (i = 0; i < 100 && d[b] !== 1'b1; i++) rd_reg(`STATUS_ADDR);
      `CHK(d[b], 1'b1)
      if (d[b] !== 1'b1) finish_test;
    end
  endtask

  // ==========================================================
  // Scenarios
  task t_reset;
    begin
      rd_reg(`SYS_CLK_STAT_ADDR); `CHK(d, 32'h0000_0001)
      rd_reg(`PER_CLK_STAT_ADDR); `CHK(d, 32'h0000_0000)
      rd_reg(8'h7C); `CHK(d, 32'h0000_0000)
    end
  endtask

  task t_periph;
    begin
      wr_reg(`PER_CLK_EN_ADDR, 32'h8000_0005);
      wr_reg(`PER_CLK_EN_ADDR, 32'h0000_0000);
      wr_reg(`PER_CLK_DIS_ADDR, 32'h0000_0004);
      wr_reg(`PER_CLK_STAT_ADDR, 32'hFFFF_FFFF);
      rd_reg(`PER_CLK_STAT_ADDR); `CHK(d, 32'h8000_0001)
      `WAITFOR(mclk) `CHK(pclk, 32'h8000_0001)
      wr_reg(`PER_CLK_DIS_ADDR, 32'h8000_0001);
      #1 `WAITFOR(mclk) `CHK(pclk, 32'h0000_0000)
    end
  endtask

  task t_proc;
    begin
      for (mc = 0; mc < 2; mc++) begin
        fast <= mc[0]; busy <= 1'b1;
        wr_reg(`SYS_CLK_DIS_ADDR, 32'h0000_0001);
        repeat (3) @(posedge clk);
        rd_reg(`SYS_CLK_STAT_ADDR); `CHK(d, 32'h0000_0001)
        busy <= 1'b0;
        repeat (2) @(posedge clk);
        rd_reg(`SYS_CLK_STAT_ADDR); `CHK(d, 32'h0000_0000)
        pc = 0;
        repeat (16) begin @(posedge clk); #1 pc += prclk; end
        `CHK(pc, 0)
        wake <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
        rd_reg(`SYS_CLK_STAT_ADDR); `CHK(d, 32'h0000_0001)
      end
    end
  endtask

  // Master clock: every prescale, then divider
  task t_master;
    begin
      run <= 1'b0;
      wr_reg(`MCLK_CFG_ADDR, 32'h0000_0001);
      rd_reg(`STATUS_ADDR); `CHK(d[3], 1'b0)
      run <= 1'b1;
      `WAITFOR(mclk)
      @(posedge clk);
      rd_reg(`STATUS_ADDR); `CHK(d[3], 1'b1)
      for (k = 0; k < 8; k++) begin
        wr_reg(`MCLK_CFG_ADDR, k == 7 ? 32'h0000_0105 : 32'h1 | (k << 2));
        mc = 0; pc = 0;
        repeat (256) begin @(posedge clk); #1 mc += mclk; pc += prclk; end
        `CHK(mc, k == 7 ? 32 : 128 >> k)
        `CHK(pc, k == 7 ? 64 : 128 >> k)
      end
      wr_reg(`MCLK_CFG_ADDR, 32'h0000_0001);
    end
  endtask

  // Pll lock, usb clock and both outputs
  task t_usb_prog;
    begin
      wr_reg(`PLL2_CFG_ADDR, 32'h0001_0401);
      rd_reg(`STATUS_ADDR); `CHK(d[2], 1'b0)
      poll(2);
      wr_reg(`PROG0_CFG_ADDR, 32'h0000_0002);
      wr_reg(`PROG1_CFG_ADDR, 32'h0000_0003);
      wr_reg(`SYS_CLK_EN_ADDR, 32'h0000_0340);
      rd_reg(`SYS_CLK_STAT_ADDR); `CHK(d, 32'h0000_0341)
      poll(8);
      poll(9);
      `WAITFOR(uclk) `CHK(uclk, 1'b1)
      mc = 0; pc = 0; p = prog;
      repeat (16) begin
        @(posedge clk); #1 mc += p[0] ^ prog[0]; pc += p[1] ^ prog[1];
        p = prog;
      end
      `CHK(mc, 4)
      `CHK(pc, 8)
      wr_reg(`SYS_CLK_DIS_ADDR, 32'h0000_0340);
      rd_reg(`SYS_CLK_STAT_ADDR); `CHK(d, 32'h0000_0001)
      `CHK(prog, 2'h0)
      rd_reg(`STATUS_ADDR); `CHK(d[9:8], 2'h0)
    end
  endtask

  task t_osc_irq;
    begin
      wr_reg(`INT_EN_ADDR, 32'h0000_0001);
      wr_reg(`MAIN_OSC_ADDR, 32'h0000_0101);
      rd_reg(`STATUS_ADDR); `CHK(d[0], 1'b0)
      `CHK(irq, 1'b0)
      poll(0);
      `CHK(irq, 1'b1)
      rd_reg(`INT_MASK_ADDR); `CHK(d, 32'h0000_0001)
      wr_reg(`INT_DIS_ADDR, 32'h0000_0001);
      #1 `CHK(irq, 1'b0)
    end
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    run <= 1'b1;
    t_reset;
    t_periph;
    t_proc;
    t_master;
    t_usb_prog;
    t_osc_irq;
    finish_test;
  end
endmodule // power_clock_manager_tb_top
